// >>> logic/hfv_pkg.sv
package hfv_pkg;
	localparam int NUM_TEMP = 4;
	localparam int NUM_SRC  = 8;

	// normalised signals: 16'h0000 is 0.0, 16'hFFFF is 1.0
	localparam logic [15:0] SIG_ZERO = 16'h0000;
	localparam logic [15:0] SIG_FULL = 16'hFFFF;
	localparam logic [15:0] SIG_HALF = 16'h8000;

	// source select: 0 is not connected, 1..8 pick a function block output
	localparam logic [3:0] SRC_NONE = 4'h0;
	localparam logic [3:0] SRC_LAST = 4'h8;
	localparam logic [2:0] PRIO_NONE = 3'h0;
	localparam logic [2:0] PRIO_LAST = 3'h4;
	localparam logic       INV_RST  = 1'b0;

	// temperatures are signed tenths of a degree Celsius
	localparam logic signed [15:0] T_MAX_RST  = 16'sh04B0;
	localparam logic signed [15:0] T_HIGH_RST = 16'sh03E8;
	localparam logic signed [15:0] T_LOW_RST  = 16'sh0320;
	localparam logic signed [15:0] T_MIN_RST  = 16'sh00C8;

	typedef logic [15:0]        hfv_sig_t;
	typedef logic signed [15:0] hfv_temp_t;

	typedef struct packed {
		logic [3:0] src;
		logic       inv;
		hfv_temp_t  t_max;
		hfv_temp_t  t_high;
		hfv_temp_t  t_low;
		hfv_temp_t  t_min;
	} hfv_tcfg_s;

	typedef struct packed {
		logic [3:0] src;
		logic       inv;
	} hfv_lcfg_s;

	typedef struct packed {
		hfv_tcfg_s [NUM_TEMP-1:0] temp;
		hfv_lcfg_s                ovr;
		hfv_lcfg_s                rev;
		hfv_lcfg_s                stp;
		logic [2:0]               prio;
	} hfv_cfg_s;

	localparam hfv_tcfg_s TCFG_RST = '{src: SRC_NONE, inv: INV_RST, t_max: T_MAX_RST,
		t_high: T_HIGH_RST, t_low: T_LOW_RST, t_min: T_MIN_RST};
	localparam hfv_lcfg_s LCFG_RST = '{src: SRC_NONE, inv: INV_RST};
	localparam hfv_cfg_s  CFG_RST  = '{temp: {NUM_TEMP{TCFG_RST}}, ovr: LCFG_RST,
		rev: LCFG_RST, stp: LCFG_RST, prio: PRIO_NONE};

	typedef enum logic [1:0] {MODE_RUN, MODE_REV, MODE_STOP} hfv_mode_e;
endpackage : hfv_pkg

// >>> logic/hfv_top.sv
`timescale 1ns/1ps
module hfv_top
	import hfv_pkg::*;
(
	input  wire logic                     clk_sys_in,
	input  wire logic                     rst_n_in,
	input  wire logic                     cfg_load_in,
	input  wire hfv_cfg_s                 cfg_in,
	input  wire hfv_sig_t [NUM_SRC-1:0]   src_in,
	output logic [15:0]                   prop_cmd_out,
	output logic                          reverse_valve_out,
	output logic                          reverse_mode_out,
	output logic                          stopped_out
);
	hfv_cfg_s               cfg_q;
	hfv_cfg_s               cfg_d;
	hfv_mode_e              mode_q;
	hfv_mode_e              mode_d;
	logic [15:0]            prop_q;
	logic [15:0]            prop_d;
	logic                   rvalve_q;
	logic                   rvalve_d;
	logic                   rmode_q;
	logic                   rmode_d;
	logic                   stop_q;
	logic                   stop_d;
	hfv_sig_t               sig_w [NUM_TEMP];
	hfv_sig_t               dem_w [NUM_TEMP];
	logic signed [17:0]     temp_w [NUM_TEMP];
	logic [NUM_TEMP-1:0]    conn_w;
	logic [NUM_TEMP-1:0]    hot_w;
	hfv_sig_t               ovr_w;
	hfv_sig_t               cmd_w;
	logic                   rev_w;
	logic                   stp_w;
	logic                   prio_ok_w;
	logic [1:0]             prio_idx_w;

	// picks the chosen source, then, if inv is set, inverts it as 1.0 minus the value
	function automatic hfv_sig_t sel_sig(input logic [3:0] src, input logic inv,
		input hfv_sig_t [NUM_SRC-1:0] s);
		hfv_sig_t v;
		v = SIG_ZERO;
		if (src != SRC_NONE && src <= SRC_LAST)
		begin
			v = s[src - 4'h1];
			if (inv)
				v = SIG_FULL - v;
		end
		return v;
	endfunction : sel_sig

	// unconnected or out-of-range selects count as absent
	function automatic logic is_conn(input logic [3:0] src);
		return (src != SRC_NONE) && (src <= SRC_LAST);
	endfunction : is_conn

	// setpoints load as one block so a half-written set never steers the fan
	always_comb
	begin
		cfg_d = cfg_load_in ? cfg_in : cfg_q;
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			cfg_q <= CFG_RST;
		else
			cfg_q <= cfg_d;
	end

	// per input: scale to degrees, then to a speed demand
	for (genvar i = 0; i < NUM_TEMP; i++)
	begin : g_temp
		hfv_tcfg_s          c;
		hfv_sig_t           sig;
		logic signed [16:0] span;
		logic signed [33:0] prod;
		logic signed [33:0] quot;
		logic signed [17:0] temp;
		logic signed [17:0] th;
		logic signed [17:0] tl;
		logic signed [17:0] diff;
		logic [33:0]        num;
		logic [33:0]        den;
		logic [33:0]        q2;
		hfv_sig_t           dem;

		always_comb
		begin
			c    = cfg_q.temp[i];
			sig  = sel_sig(c.src, c.inv, src_in);
			span = $signed({c.t_max[15], c.t_max}) - $signed({c.t_min[15], c.t_min});
			prod = $signed({1'b0, sig}) * span;
			quot = prod / $signed({18'h00000, SIG_FULL});
			// ends of the scale land exactly on t_min and t_max
			temp = $signed({{2{c.t_min[15]}}, c.t_min}) + $signed(quot[17:0]);
			th   = $signed({{2{c.t_high[15]}}, c.t_high});
			tl   = $signed({{2{c.t_low[15]}}, c.t_low});
			diff = temp - tl;
			num  = {16'h0000, diff} * {18'h00000, SIG_FULL};
			// divider runs only while temp lies between t_low and t_high, so den is never zero
			den  = {16'h0000, th - tl};
			q2   = '0;
			if (!is_conn(c.src))
				dem = SIG_ZERO;
			else if (temp >= th)
				dem = SIG_FULL;
			else if (temp <= tl)
				dem = SIG_ZERO;
			else
			begin
				q2  = num / den;
				dem = q2[15:0];
			end
		end

		assign sig_w[i]  = sig;
		assign temp_w[i] = temp;
		assign dem_w[i]  = dem;
		assign conn_w[i] = is_conn(c.src);
		assign hot_w[i]  = is_conn(c.src) && (temp >= th);
	end

	// logical inputs count as asserted from half scale upward
	assign ovr_w = sel_sig(cfg_q.ovr.src, cfg_q.ovr.inv, src_in);
	assign rev_w = sel_sig(cfg_q.rev.src, cfg_q.rev.inv, src_in) >= SIG_HALF;
	assign stp_w = sel_sig(cfg_q.stp.src, cfg_q.stp.inv, src_in) >= SIG_HALF;

	// command select: priority input wins only while no other input runs hot
	always_comb
	begin
		prio_idx_w = 2'(cfg_q.prio - 3'h1);
		prio_ok_w  = (cfg_q.prio != PRIO_NONE) && (cfg_q.prio <= PRIO_LAST) && conn_w[prio_idx_w]
			&& ((hot_w & ~(4'h1 << prio_idx_w)) == 4'h0);
		cmd_w = ovr_w;
		for (int k = 0; k < NUM_TEMP; k++)
		begin
			if (dem_w[k] > cmd_w)
				cmd_w = dem_w[k];
		end
		if (prio_ok_w)
			cmd_w = dem_w[prio_idx_w];
	end

	// mode sequence: stop beats reverse, and leaving stop goes back to run
	always_comb
	begin
		mode_d = mode_q;
		if (stp_w)
			mode_d = MODE_STOP;
		else
			unique case (mode_q)
				MODE_STOP: mode_d = MODE_RUN;
				MODE_RUN:  mode_d = rev_w ? MODE_REV : MODE_RUN;
				MODE_REV:  mode_d = rev_w ? MODE_REV : MODE_RUN;
			endcase
		prop_d   = (mode_d == MODE_STOP) ? SIG_ZERO : cmd_w;
		rvalve_d = (mode_d == MODE_REV);
		// mode flags get their own flops so the pins carry no decode glitches
		rmode_d  = (mode_d == MODE_REV);
		stop_d   = (mode_d == MODE_STOP);
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			mode_q   <= MODE_RUN;
			prop_q   <= SIG_ZERO;
			rvalve_q <= 1'b0;
			rmode_q  <= 1'b0;
			stop_q   <= 1'b0;
		end
		else
		begin
			mode_q   <= mode_d;
			prop_q   <= prop_d;
			rvalve_q <= rvalve_d;
			rmode_q  <= rmode_d;
			stop_q   <= stop_d;
		end
	end

	assign prop_cmd_out      = prop_q;
	assign reverse_valve_out = rvalve_q;
	assign reverse_mode_out  = rmode_q;
	assign stopped_out       = stop_q;

	// checks
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence stop_release;
		stp_w ##1 !stp_w;
	endsequence

	cmd_track_a: assert property (!stp_w |=> prop_cmd_out == $past(cmd_w))
		else $error("valve command does not follow demand");
	rev_valve_a: assert property (rev_w && !stp_w && !stopped_out |=> reverse_valve_out && reverse_mode_out)
		else $error("reverse input did not open reverse valve");
	stop_exit_a: assert property (stop_release |-> stopped_out ##1 !stopped_out)
		else $error("stop release did not return to run");
	invert_a: assert property (conn_w[0] && cfg_q.temp[0].inv
		|-> sig_w[0] == SIG_FULL - src_in[cfg_q.temp[0].src - 4'h1])
		else $error("inversion not applied");
	unconn_a: assert property (!conn_w[1] |-> dem_w[1] == SIG_ZERO && !hot_w[1])
		else $error("unconnected input makes demand");
	full_scale_a: assert property (conn_w[0] && sig_w[0] == SIG_FULL
		|-> temp_w[0] == $signed({cfg_q.temp[0].t_max[15], cfg_q.temp[0].t_max}))
		else $error("full scale not at t_max");
	zero_scale_a: assert property (sig_w[2] == SIG_ZERO
		|-> temp_w[2] == $signed({cfg_q.temp[2].t_min[15], cfg_q.temp[2].t_min}))
		else $error("zero scale not at t_min");
	max_speed_a: assert property (hot_w[0] && !stp_w && cfg_q.prio == PRIO_NONE
		|=> prop_cmd_out == SIG_FULL)
		else $error("hot input did not give full speed");
	min_speed_a: assert property (conn_w[3]
		&& temp_w[3] <= $signed({cfg_q.temp[3].t_low[15], cfg_q.temp[3].t_low}) |-> dem_w[3] == SIG_ZERO)
		else $error("cold input makes demand");
	stop_off_a: assert property (stp_w |=> prop_cmd_out == SIG_ZERO && !reverse_valve_out && stopped_out)
		else $error("stop left a valve on");
	prio_rule_a: assert property (prio_ok_w && !stp_w |=> prop_cmd_out == $past(dem_w[prio_idx_w]))
		else $error("priority input ignored");
	linear_a: assert property (conn_w[1] && !hot_w[1]
		&& temp_w[1] > $signed({cfg_q.temp[1].t_low[15], cfg_q.temp[1].t_low})
		|-> dem_w[1] < SIG_FULL && dem_w[1] != SIG_ZERO)
		else $error("mid range demand out of span");
	highest_a: assert property (!prio_ok_w && !stp_w |=> prop_cmd_out >= $past(ovr_w)
		&& prop_cmd_out >= $past(dem_w[0]) && prop_cmd_out >= $past(dem_w[3]))
		else $error("command below a demand");
endmodule : hfv_top

// >>> dv/hfv_fan_valves.sv
`timescale 1ns/1ps
// valve pair at the fan: flow follows the command, no spool lag modelled
module hfv_fan_valves
	import hfv_pkg::*;
(
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	input  wire logic [15:0] prop_cmd_in,
	input  wire logic        reverse_on_in,
	output logic [15:0]      flow_out,
	output logic             fan_idle_out
);
	// spools closed at reset, so the fan starts idle
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			flow_out     <= 16'h0000;
			fan_idle_out <= 1'b1;
		end
		else
		begin
			flow_out     <= prop_cmd_in;
			fan_idle_out <= (prop_cmd_in == 16'h0000) && !reverse_on_in;
		end
	end
endmodule : hfv_fan_valves

// >>> dv/tb_hfv_top.sv
`timescale 1ns/1ps
module tb_hfv_top;
	import hfv_pkg::*;
	logic                   clk_sys_in;
	logic                   rst_n_in;
	logic                   cfg_load_in;
	hfv_cfg_s               cfg_in;
	hfv_cfg_s               cfg;
	hfv_sig_t [NUM_SRC-1:0] src_in;
	logic [15:0]            prop_cmd_out;
	logic [15:0]            flow;
	logic                   reverse_valve_out;
	logic                   reverse_mode_out;
	logic                   stopped_out;
	logic                   fan_idle;
	int                     miscompares;
	int                     num_checks;

	hfv_top u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cfg_load_in(cfg_load_in),
		.cfg_in(cfg_in), .src_in(src_in), .prop_cmd_out(prop_cmd_out),
		.reverse_valve_out(reverse_valve_out), .reverse_mode_out(reverse_mode_out),
		.stopped_out(stopped_out));
	hfv_fan_valves u_valves (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.prop_cmd_in(prop_cmd_out), .reverse_on_in(reverse_valve_out),
		.flow_out(flow), .fan_idle_out(fan_idle));

	// 200 MHz system clock
	initial
	begin
		clk_sys_in = 1'b0;
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end

	task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk

	// expected demand of one input; longint keeps signed thresholds exact
	function automatic logic [15:0] dmd(hfv_tcfg_s c, hfv_sig_t s);
		longint v;
		longint t;
		longint lo;
		longint hi;
		longint mn;
		longint mx;
		v = c.inv ? 65535 - longint'(s) : longint'(s);
		mn = c.t_min;
		mx = c.t_max;
		lo = c.t_low;
		hi = c.t_high;
		t = mn + v * (mx - mn) / 65535;
		if (t >= hi)
			return 16'hFFFF;
		if (t <= lo)
			return 16'h0000;
		return 16'((t - lo) * 65535 / (hi - lo));
	endfunction : dmd

	// one source changes, then outputs are left to settle
	task automatic put(int i, hfv_sig_t v);
		@(posedge clk_sys_in);
		src_in[i] <= v;
		repeat (3) @(posedge clk_sys_in);
		#1;
	endtask : put

	task automatic load();
		@(posedge clk_sys_in);
		cfg_in      <= cfg;
		cfg_load_in <= 1'b1;
		@(posedge clk_sys_in);
		cfg_load_in <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
		#1;
	endtask : load

	task automatic t_dflt();
		for (int i = 0; i < NUM_SRC; i++)
			put(i, 16'hFFFF);
		chk("prop", prop_cmd_out, 16'h0000);
		chk("rvalve", reverse_valve_out, 1'b0);
		chk("stopped", stopped_out, 1'b0);
		$display("test defaults done");
	endtask : t_dflt

	task automatic t_scale();
		hfv_sig_t v[6] = '{16'h0000, 16'h8000, 16'hB000, 16'hC000, 16'hCCCC, 16'hFFFF};
		cfg.temp[0].src = 4'h1;
		load();
		foreach (v[i])
		begin
			put(0, v[i]);
			chk("scale", prop_cmd_out, dmd(cfg.temp[0], v[i]));
			chk("flow", flow, dmd(cfg.temp[0], v[i]));
		end
		cfg.temp[0].inv = 1'b1;
		load();
		put(0, 16'h0000);
		chk("inv", prop_cmd_out, 16'hFFFF);
		$display("test scale done");
	endtask : t_scale

	task automatic t_mix();
		cfg.temp[0].inv = 1'b0;
		cfg.temp[1].src = 4'h2;
		cfg.temp[1].t_high = 16'sh0384;
		cfg.ovr.src = 4'h3;
		cfg.temp[3].src = 4'h8;
		load();
		// fourth input held cold so it never outbids the others
		put(7, 16'h0000);
		put(0, 16'hB000);
		put(1, 16'hA000);
		put(2, 16'hF000);
		chk("ovr", prop_cmd_out, 16'hF000);
		put(2, 16'h1234);
		chk("max0", prop_cmd_out, dmd(cfg.temp[0], 16'hB000));
		put(1, 16'hB000);
		chk("max1", prop_cmd_out, dmd(cfg.temp[1], 16'hB000));
		$display("test highest demand done");
	endtask : t_mix

	task automatic t_prio();
		cfg.prio = 3'h1;
		load();
		put(2, 16'hFFFF);
		chk("prio", prop_cmd_out, dmd(cfg.temp[0], 16'hB000));
		put(1, 16'hC000);
		chk("prio_off", prop_cmd_out, 16'hFFFF);
		$display("test priority done");
	endtask : t_prio

	// stop is inverted here, so a low source means stop
	task automatic t_rs();
		cfg.prio = PRIO_NONE;
		cfg.rev.src = 4'h4;
		cfg.stp.src = 4'h5;
		cfg.stp.inv = 1'b1;
		put(4, 16'hFFFF);
		load();
		put(3, 16'h7FFF);
		chk("rev_low", reverse_valve_out, 1'b0);
		put(3, 16'h8000);
		chk("rev_valve", reverse_valve_out, 1'b1);
		chk("rev_mode", reverse_mode_out, 1'b1);
		put(4, 16'h0000);
		chk("stop_prop", prop_cmd_out, 16'h0000);
		chk("stop_valve", reverse_valve_out, 1'b0);
		chk("stopped", stopped_out, 1'b1);
		chk("idle", fan_idle, 1'b1);
		put(3, 16'h0000);
		put(4, 16'hFFFF);
		chk("run", stopped_out, 1'b0);
		chk("resume", prop_cmd_out, 16'hFFFF);
		$display("test reverse stop done");
	endtask : t_rs

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out

	initial
	begin
		rst_n_in    = 1'b0;
		cfg_load_in = 1'b0;
		cfg_in      = CFG_RST;
		cfg         = CFG_RST;
		src_in      = '0;
		miscompares = 0;
		num_checks  = 0;
		repeat (3) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		t_dflt();
		t_scale();
		t_mix();
		t_prio();
		t_rs();
		close_out();
	end

	// run needs about 150 cycles; twenty times that is a hang
	initial
	begin
		#15000;
		miscompares++;
		close_out();
	end
endmodule : tb_hfv_top
